/* sim/rmpu_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rmpu_core_model (
  input  wire logic        pclk,
  input  wire logic        res_valid,
  input  wire logic        res_fault,
  input  wire logic        res_strong_order,
  input  wire logic        res_shareable,
  output logic             acc_valid,
  output logic [31:0]      acc_addr,
  output logic             acc_priv,
  output logic             acc_fetch,
  output logic             acc_write,
  output logic             acc_fault_handler
);
  initial begin
    acc_valid = 1'b0;
    acc_addr = 32'h0;
    acc_priv = 1'b0;
    acc_fetch = 1'b0;
    acc_write = 1'b0;
    acc_fault_handler = 1'b0;
  end
  // one access per call, result sampled in the cycle it stands
  task automatic access(input logic [31:0] a, input logic pr, fe, wr, fh,
                        output logic v, f, so, sh);
    @(posedge pclk);
    acc_valid <= 1'b1;
    acc_addr <= a;
    acc_priv <= pr;
    acc_fetch <= fe;
    acc_write <= wr;
    acc_fault_handler <= fh;
    @(posedge pclk);
    acc_valid <= 1'b0;
    // released lines other than acc_fault_handler show no stale value
    acc_addr <= ~a;
    acc_priv <= ~pr;
    acc_fetch <= ~fe;
    acc_write <= ~wr;
    @(negedge pclk);
    v = res_valid;
    f = res_fault;
    so = res_strong_order;
    sh = res_shareable;
  endtask
endmodule
`default_nettype wire

/* sim/rmpu_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module rmpu_tb_top;
  import rmpu_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, acc_addr, q;
  logic        acc_valid, acc_priv, acc_fetch, acc_write, acc_fault_handler;
  logic        res_valid, res_fault, res_strong_order, res_shareable;
  logic        res_cacheable, res_bufferable, xf;
  logic        v, f, so, sh, e;
  int          num_errors, num_checks;

  initial pclk = 1'b0;
  always #25 pclk = ~pclk;

  rmpu_top #(.NREG(8)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_priv(acc_priv),
    .acc_fetch(acc_fetch), .acc_write(acc_write),
    .acc_fault_handler(acc_fault_handler), .res_valid(res_valid),
    .res_fault(res_fault), .res_strong_order(res_strong_order),
    .res_shareable(res_shareable), .res_cacheable(res_cacheable),
    .res_bufferable(res_bufferable));

  rmpu_core_model core (.pclk(pclk), .res_valid(res_valid),
    .res_fault(res_fault), .res_strong_order(res_strong_order),
    .res_shareable(res_shareable), .acc_valid(acc_valid),
    .acc_addr(acc_addr), .acc_priv(acc_priv), .acc_fetch(acc_fetch),
    .acc_write(acc_write), .acc_fault_handler(acc_fault_handler));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic tally_and_finish;
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait for the slave
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    check(nm, q, x);
  endtask

  // region setup; base write with valid bit also selects the region
  task automatic cfg(input logic [2:0] r, input logic [31:0] b, attr);
    wr(OFS_RNR, {29'h0, r});
    wr(OFS_RASR, attr);
    wr(OFS_RBAR, b | 32'h10 | {29'h0, r});
  endtask

  task automatic acc(input logic [31:0] a, input logic pr, fe, w, fh, ef);
    core.access(a, pr, fe, w, fh, v, f, so, sh);
    check("res_valid", {31'h0, v}, 32'h1);
    check("res_fault", {31'h0, f}, {31'h0, ef});
  endtask

  function automatic logic apf(input int ap, input logic pr, w);
    case (ap)
      0: apf = 1'b1;
      1: apf = !pr;
      2: apf = !pr && w;
      3: apf = 1'b0;
      5: apf = !pr || w;
      default: apf = w;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    #250000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc("rasr", OFS_RASR, 32'h0000000E);
    acc(32'h20000000, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    wr(OFS_CTRL, 32'h4);
    acc(32'h60000000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    acc(SCS_BASE, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    check("strong", {31'h0, so}, 32'h1);
    cfg(3'h0, 32'h200003E0, 32'h03040013);
    rdc("rbar", OFS_RBAR, 32'h20000000);
    wr(OFS_RNR, 32'h000000FF);
    rdc("rnr", OFS_RNR, 32'h7);
    wr(OFS_RBAR, 32'h00000013);
    rdc("rnr", OFS_RNR, 32'h3);
    rdc("rbar", OFS_RBAR, 32'h00000003);
    wr(OFS_CTRL, 32'h1);
    acc(32'h20000004, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    check("share", {31'h0, sh}, 32'h1);
    check("order", {31'h0, so}, 32'h1);
    check("cache", {31'h0, res_cacheable}, 32'h0);
    acc(32'h30000000, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
    acc(32'hE000ED00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    acc(32'h00000040, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    acc(32'h30000000, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
    wr(OFS_CTRL, 32'h3);
    acc(32'h30000000, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1);
    wr(OFS_CTRL, 32'h5);
    acc(32'h30000000, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    acc(32'h30000000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    wr(OFS_CTRL, 32'h1);
    for (int ap = 0; ap < 8; ap++) begin
      if (ap != 4) begin
        cfg(3'h0, 32'h20000000, {5'h0, ap[2:0], 24'h000013});
        for (int k = 0; k < 4; k++) begin
          xf = apf(ap, k[1], k[0]);
          acc(32'h20000008, k[1], 1'b0, k[0], 1'b0, xf);
        end
      end
    end
    cfg(3'h0, 32'h20000000, 32'h13000013);
    acc(32'h20000008, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1);
    acc(32'h20000008, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    cfg(3'h0, 32'h20000000, 32'h03000013);
    acc(32'h20000008, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    cfg(3'h1, 32'h20000000, 32'h00000113);
    acc(32'h20000010, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    acc(32'h20000090, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    cfg(3'h7, 32'h0, 32'hFFFF00FF);
    rdc("rasr", OFS_RASR, 32'h1707003F);
    acc(32'h90000000, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    check("cache", {31'h0, res_cacheable}, 32'h1);
    check("buffer", {31'h0, res_bufferable}, 32'h1);
    check("order", {31'h0, so}, 32'h0);
    acc(32'h90000000, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    acc(32'h20000090, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    apb(1'b0, 8'h40, 32'h0);
    check("slverr", {31'h0, e}, 32'h1);
    check("unmapped", q, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire

/* src/rmpu_pkg.sv */
package rmpu_pkg;

  // register byte offsets within the unit's APB window
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_RNR  = 8'h08;
  localparam logic [7:0] OFS_RBAR = 8'h0C;
  localparam logic [7:0] OFS_RASR = 8'h10;

  // control fields
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_HFNM_BIT = 1;
  localparam int CTRL_BG_BIT   = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;

  // base register fields
  localparam int RBAR_VALID_BIT = 4;
  localparam int RBAR_ADDR_LSB  = 5;

  // attribute register fields
  localparam int RASR_EN_BIT   = 0;
  localparam int RASR_SIZE_LSB = 1;
  localparam int RASR_SRD_LSB  = 8;
  localparam int RASR_B_BIT    = 16;
  localparam int RASR_C_BIT    = 17;
  localparam int RASR_S_BIT    = 18;
  localparam int RASR_AP_LSB   = 24;
  localparam int RASR_XN_BIT   = 28;
  localparam logic [4:0] SIZE_MIN = 5'h07;
  localparam logic [4:0] SIZE_MAX = 5'h1F;

  // system control space window (never execute, strongly ordered)
  localparam logic [31:0] SCS_BASE = 32'hE000E000;
  localparam logic [31:0] SCS_MASK = 32'hFFFFF000;
  // vector table window
  localparam logic [31:0] VTAB_LIMIT = 32'h000000C0;

  // default map: addresses from 0xA0000000 up not executable
  localparam logic [31:0] XN_DEFAULT_FROM = 32'hA0000000;

endpackage

/* src/rmpu_top.sv */
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module rmpu_top
  import rmpu_pkg::*;
#(
  parameter int NREG = 8
) (
  input  wire  logic        pclk,
  input  wire  logic        presetn,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [7:0]  paddr,
  input  wire  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  input  wire  logic        acc_valid,
  input  wire  logic [31:0] acc_addr,
  input  wire  logic        acc_priv,
  input  wire  logic        acc_fetch,
  input  wire  logic        acc_write,
  input  wire  logic        acc_fault_handler,
  output logic        res_valid,
  output logic        res_fault,
  output logic        res_strong_order,
  output logic        res_shareable,
  output logic        res_cacheable,
  output logic        res_bufferable
);

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [2:0]  ctrl_r;
  logic [7:0]  sel_r;
  logic [26:0] base_r  [NREG];
  logic        en_r    [NREG];
  logic [4:0]  size_r  [NREG];
  logic [7:0]  srd_r   [NREG];
  logic [2:0]  ap_r    [NREG];
  logic        xn_r    [NREG];
  logic        s_r     [NREG];
  logic        c_r     [NREG];
  logic        b_r     [NREG];

  logic wr_en;
  logic rd_en;
  logic [2:0] wsel;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;

  function automatic logic known_ofs(input logic [7:0] a);
    known_ofs = (a == OFS_CTRL) || (a == OFS_RNR) ||
                (a == OFS_RBAR) || (a == OFS_RASR);
  endfunction

  // mask of the base bits kept for a size field
  function automatic logic [31:0] size_mask(input logic [4:0] sz);
    if (sz == SIZE_MAX) begin
      size_mask = 32'h00000000;
    end else begin
      size_mask = ~((32'h00000002 << sz) - 32'h00000001);
    end
  endfunction

  assign pslverr = psel && penable && !known_ofs(paddr);

  // base write with valid redirects to its own region field
  assign wsel = (pwdata[RBAR_VALID_BIT] && paddr == OFS_RBAR) ?
                pwdata[2:0] : sel_r[2:0];

  // ---------------------------------------------------------------
  // control and selector
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_en && paddr == OFS_CTRL) begin
      ctrl_r <= pwdata[2:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_r <= 8'h00;
    end else if (wr_en && paddr == OFS_RNR) begin
      sel_r <= {5'h00, pwdata[2:0]};
    end else if (wr_en && paddr == OFS_RBAR &&
                 pwdata[RBAR_VALID_BIT]) begin
      sel_r <= {4'h0, pwdata[3:0]} & 8'h07;
    end
  end

  // ---------------------------------------------------------------
  // region tables
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NREG; i++) begin
        en_r[i]   <= 1'b0;
        size_r[i] <= SIZE_MIN;
        srd_r[i]  <= 8'h00;
        ap_r[i]   <= 3'h0;
        xn_r[i]   <= 1'b0;
        s_r[i]    <= 1'b0;
        c_r[i]    <= 1'b0;
        b_r[i]    <= 1'b0;
      end
    end else if (wr_en && paddr == OFS_RASR) begin
      en_r[sel_r[2:0]]   <= pwdata[RASR_EN_BIT];
      size_r[sel_r[2:0]] <= (pwdata[5:1] < SIZE_MIN) ? SIZE_MIN
                                                      : pwdata[5:1];
      srd_r[sel_r[2:0]]  <= pwdata[15:8];
      ap_r[sel_r[2:0]]   <= pwdata[26:24];
      xn_r[sel_r[2:0]]   <= pwdata[RASR_XN_BIT];
      s_r[sel_r[2:0]]    <= pwdata[RASR_S_BIT];
      c_r[sel_r[2:0]]    <= pwdata[RASR_C_BIT];
      b_r[sel_r[2:0]]    <= pwdata[RASR_B_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NREG; i++) begin
        base_r[i] <= 27'h0000000;
      end
    end else if (wr_en && paddr == OFS_RBAR) begin
      base_r[wsel] <= pwdata[31:5];
    end
  end

  // ---------------------------------------------------------------
  // register read-back
  // ---------------------------------------------------------------
  logic [31:0] rd_mux;
  logic [31:0] bmask;
  assign bmask = size_mask(size_r[sel_r[2:0]]);
  always_comb begin
    rd_mux = 32'h00000000;
    if (paddr == OFS_CTRL) begin
      rd_mux = {29'h00000000, ctrl_r};
    end else if (paddr == OFS_RNR) begin
      rd_mux = {24'h000000, sel_r};
    end else if (paddr == OFS_RBAR) begin
      // valid reads zero, low field mirrors the selector
      rd_mux = ({base_r[sel_r[2:0]], 5'h00} & bmask) |
               {28'h0000000, sel_r[3:0]};
    end else if (paddr == OFS_RASR) begin
      rd_mux = {3'h0, xn_r[sel_r[2:0]], 1'b0, ap_r[sel_r[2:0]],
                5'h00, s_r[sel_r[2:0]], c_r[sel_r[2:0]],
                b_r[sel_r[2:0]], srd_r[sel_r[2:0]], 2'h0,
                size_r[sel_r[2:0]], en_r[sel_r[2:0]]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // access check
  // ---------------------------------------------------------------
  logic       hit;
  logic [2:0] win;
  logic       mpu_on;
  logic       in_scs;
  logic       in_vtab;
  logic       perm_ok;
  logic       chk_fault;

  // does region i cover the address, subregions included
  function automatic logic region_hit(input logic [31:0] a,
                                      input logic [26:0] bs,
                                      input logic [4:0]  sz,
                                      input logic [7:0]  subregion_disable_mask);
    logic [31:0] m;
    logic [2:0]  sub;
    m = size_mask(sz);
    sub = 3'((a >> (sz - 5'h02)) & 32'h00000007);
    if (sz == SIZE_MAX) begin
      sub = a[31:29];
    end
    region_hit = (((a ^ {bs, 5'h00}) & m) == 32'h00000000) &&
                 !subregion_disable_mask[sub];
  endfunction

  // permission decode
  function automatic logic ap_ok(input logic [2:0] ap,
                                 input logic pr, input logic wr);
    case (ap)
      3'h1:    ap_ok = pr;
      3'h2:    ap_ok = pr || !wr;
      3'h3:    ap_ok = 1'b1;
      3'h5:    ap_ok = pr && !wr;
      3'h6,
      3'h7:    ap_ok = !wr;
      default: ap_ok = 1'b0;
    endcase
  endfunction

  always_comb begin
    hit = 1'b0;
    win = 3'h0;
    for (int i = 0; i < NREG; i++) begin
      if (en_r[i] && region_hit(acc_addr, base_r[i], size_r[i],
                                srd_r[i])) begin
        hit = 1'b1;
        win = 3'(i);
      end
    end
  end

  assign in_scs  = (acc_addr & SCS_MASK) == SCS_BASE;
  assign in_vtab = acc_addr < VTAB_LIMIT;
  // off outright, or suspended in top-priority handlers
  assign mpu_on  = ctrl_r[CTRL_EN_BIT] &&
                   !(acc_fault_handler && !ctrl_r[CTRL_HFNM_BIT]);
  assign perm_ok = ap_ok(ap_r[win], acc_priv, acc_write) &&
                   !(acc_fetch && xn_r[win]);

  always_comb begin
    chk_fault = 1'b0;
    if (acc_fetch && in_scs) begin
      chk_fault = 1'b1;
    end else if (!mpu_on) begin
      chk_fault = acc_fetch && acc_addr >= XN_DEFAULT_FROM;
    end else if (in_scs || in_vtab) begin
      chk_fault = 1'b0;
    end else if (hit) begin
      chk_fault = !perm_ok;
    end else if (ctrl_r[CTRL_BG_BIT] && acc_priv) begin
      chk_fault = acc_fetch && acc_addr >= XN_DEFAULT_FROM;
    end else begin
      chk_fault = 1'b1;
    end
  end

  // result registered one cycle after the access is presented
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_valid        <= 1'b0;
      res_fault        <= 1'b0;
      res_strong_order <= 1'b0;
      res_shareable    <= 1'b0;
      res_cacheable    <= 1'b0;
      res_bufferable   <= 1'b0;
    end else begin
      res_valid        <= acc_valid;
      res_fault        <= acc_valid && chk_fault;
      res_strong_order <= in_scs || (mpu_on && hit &&
                          !c_r[win] && !b_r[win]);
      res_shareable    <= mpu_on && hit && s_r[win];
      res_cacheable    <= mpu_on && hit && c_r[win];
      res_bufferable   <= mpu_on && hit && b_r[win];
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_scs_fetch;
    acc_valid && acc_fetch && in_scs;
  endsequence

  property p_scs_xn;
    @(posedge pclk) disable iff (!presetn)
      s_scs_fetch |=> res_fault;
  endproperty
  a_scs_xn: assert property (p_scs_xn)
    else $error("fetch from control space not faulted");

  property p_off_default;
    @(posedge pclk) disable iff (!presetn)
      acc_valid && !ctrl_r[CTRL_EN_BIT] && !acc_fetch |=> !res_fault;
  endproperty
  a_off_default: assert property (p_off_default)
    else $error("data access faulted with protection off");

  property p_miss_fault;
    @(posedge pclk) disable iff (!presetn)
      acc_valid && ctrl_r == 3'h1 && !acc_fault_handler && !hit &&
      !in_scs && !in_vtab |=> res_fault;
  endproperty
  a_miss_fault: assert property (p_miss_fault)
    else $error("miss without background did not fault");

  property p_unpriv_miss;
    @(posedge pclk) disable iff (!presetn)
      acc_valid && ctrl_r == 3'h5 && !acc_priv && !hit &&
      !acc_fault_handler && !in_scs && !in_vtab |=> res_fault;
  endproperty
  a_unpriv_miss: assert property (p_unpriv_miss)
    else $error("unprivileged miss did not fault");

  property p_handler_off;
    @(posedge pclk) disable iff (!presetn)
      acc_valid && acc_fault_handler && !ctrl_r[CTRL_HFNM_BIT] &&
      !acc_fetch |=> !res_fault;
  endproperty
  a_handler_off: assert property (p_handler_off)
    else $error("checks active in handler");

  property p_vtab_ok;
    @(posedge pclk) disable iff (!presetn)
      acc_valid && ctrl_r[CTRL_EN_BIT] && in_vtab |=> !res_fault;
  endproperty
  a_vtab_ok: assert property (p_vtab_ok)
    else $error("vector table access faulted");

  property p_valid_sel;
    @(posedge pclk) disable iff (!presetn)
      wr_en && paddr == OFS_RBAR && pwdata[RBAR_VALID_BIT]
      |=> sel_r == {5'h00, $past(pwdata[2:0])};
  endproperty
  a_valid_sel: assert property (p_valid_sel)
    else $error("selector not updated by base write");

  property p_sel_range;
    @(posedge pclk) disable iff (!presetn)
      sel_r <= 8'h07;
  endproperty
  a_sel_range: assert property (p_sel_range)
    else $error("selector out of range");

  property p_ap_zero;
    @(posedge pclk) disable iff (!presetn)
      acc_valid && mpu_on && hit && ap_r[win] == 3'h0 &&
      !in_scs && !in_vtab |=> res_fault;
  endproperty
  a_ap_zero: assert property (p_ap_zero)
    else $error("no-access region permitted access");

  property p_xn_fetch;
    @(posedge pclk) disable iff (!presetn)
      acc_valid && mpu_on && hit && acc_fetch && xn_r[win] &&
      !in_scs && !in_vtab |=> res_fault;
  endproperty
  a_xn_fetch: assert property (p_xn_fetch)
    else $error("fetch from execute-never region permitted");

endmodule
`default_nettype wire
